// [rtl/scd_bank_mem.sv]
// One memory bank: synchronous write, registered read data
`timescale 1ns/1ps

module scd_bank_mem #(
   parameter int WIDTH = 32,
   parameter int AW    = 20
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] store [0:(1<<AW)-1];

   // -------------------------------------------------------------------
   // Array write, committed only while the column strobe qualifies it
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         store[wr_addr] <= wdata;
      end
   end

   // Read data always comes from a register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= store[addr];
      end
   end

endmodule : scd_bank_mem

// [rtl/scd_pkg.sv]
// Constants and types shared by the interleaved static-column memory port
package scd_pkg;

   // -------------------------------------------------------------------
   // Geometry
   // -------------------------------------------------------------------
   localparam int WORD_W    = 32;             // Bits per word
   localparam int BANK_AW   = 20;             // One mega-word per bank
   localparam int WORD_AW   = BANK_AW + 1;    // Word address over both banks
   localparam int NUM_BANKS = 2;              // Even and odd bank

   // -------------------------------------------------------------------
   // Bank numbering and reset values
   // -------------------------------------------------------------------
   localparam logic BANK_EVEN = 1'b0;
   localparam logic BANK_ODD  = 1'b1;
   localparam logic STROBE_IDLE_N = 1'b1;     // Row and column strobes idle high

   // -------------------------------------------------------------------
   // Latency figures in clock cycles, decode cycle included
   // -------------------------------------------------------------------
   localparam int INIT_LAT_FAST   = 4;        // Nonsequential, fast parts
   localparam int INIT_LAT_SLOW   = 5;        // Nonsequential, slow parts
   localparam int PRECHARGE_CYC   = 1;        // Added between row addresses
   localparam int BANK_WORD_CYC   = 2;        // Each bank per burst word
   localparam int BURST_WORD_CYC  = 1;        // Bus rate after first word

   // -------------------------------------------------------------------
   // Controller states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,      // Decode cycle, also precharge between sequences
      ST_ROW,       // Row strobe low, row address held
      ST_COL,       // Column strobe low, first column access
      ST_WAIT,      // Extra access cycle for slow parts
      ST_ACCESS,    // Burst words, active or suspended
      ST_PRE,       // Precharge before the next row address
      ST_REF1,      // Refresh, first cycle
      ST_REF2       // Refresh, second cycle
   } state_t;

endpackage : scd_pkg

// [rtl/scd_port.sv]
// Interleaved static-column memory block: controller, ports and two banks
`timescale 1ns/1ps
// Function
// - Nonsequential access: one decode cycle plus three, first word in four.
// - Slow parts fitted: initial latency stretched to five cycles.
// - Each bank takes two cycles per word; banks overlap to hide it.
// - After the first word, one word per cycle alternating banks.
// - Two banks, even and odd words, each 1M by 32 bits.
// - Instruction port is read-only; data port reads and writes it too.
// - Data memory block has only the read/write data-bus port.
// - Data-bus drivers stay off while instruction words are fetched.
// - Registered column strobe is the qualifier that commits a write.
// - Write data held in one latch set per bank, opened by active bank.
// - Writes release the bus one cycle earlier than reads.
// - Inside an open row only the column changes; strobe not recycled.
// - No open-row compare; every nonsequential access precharges.
// - Preempt and precharge add a cycle each, six cycles back to back.
// - Instruction drivers isolate even and odd banks and other blocks.
// - Each bank delivers sequential words within two clock cycles.
// - Each bank has its own counter; word counter LSB names the bank.
// - Pending refresh in idle wins over waiting accesses.

module interleaved_static_column_dram_port #(
   parameter int  WIDTH     = scd_pkg::WORD_W,
   parameter int  BANK_AW   = scd_pkg::BANK_AW,
   parameter bit  HAS_IPORT = 1'b1             // 1: instruction block, 0: data block
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Configuration pin
   input  wire logic                 slow_parts,
   // Instruction bus, read-only
   input  wire logic                 ireq,
   input  wire logic [BANK_AW:0]     iaddr,
   input  wire logic                 ibreq,
   output logic                      irdy,
   output logic      [WIDTH-1:0]     idata,
   output logic                      ibus_oe_even,
   output logic                      ibus_oe_odd,
   // Data bus, read and write
   input  wire logic                 dreq,
   input  wire logic [BANK_AW:0]     daddr,
   input  wire logic                 dwrite,
   input  wire logic                 dbreq,
   input  wire logic [WIDTH-1:0]     dbus_wdata,
   output logic                      drdy,
   output logic      [WIDTH-1:0]     dbus_rdata,
   output logic                      dbus_oe,
   // Refresh
   input  wire logic                 refresh_req,
   output logic                      refresh_ack,
   // Memory strobes and bank indicator
   output logic                      ras_n,
   output logic                      cas_n,
   output logic                      active_bank_flag
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   scd_pkg::state_t  state;
   scd_pkg::state_t  next_state;
   logic             slow_meta;
   logic             slow;
   logic             acc_data;
   logic             acc_write;
   logic             got_first;
   logic             past_first;
   logic [BANK_AW:0] word_addr;
   logic [BANK_AW-1:0] bank_addr   [scd_pkg::NUM_BANKS];
   logic [BANK_AW-1:0] latch_addr  [scd_pkg::NUM_BANKS];
   logic [WIDTH-1:0]   latch_data  [scd_pkg::NUM_BANKS];
   logic               latch_full  [scd_pkg::NUM_BANKS];
   logic [WIDTH-1:0]   bank_rdata  [scd_pkg::NUM_BANKS];
   logic               bank_wr     [scd_pkg::NUM_BANKS];
   logic             i_take;
   logic             d_take;
   logic             start;
   logic             start_data;
   logic             start_write;
   logic [BANK_AW:0] start_addr;
   logic             first_slot;
   logic             burst_req;
   logic             preempt;
   logic             deliver;
   logic             bank;

   // Which bank a word address falls in, and its word index within that bank
   function automatic logic bank_of(input logic [BANK_AW:0] a);
      return a[0];
   endfunction : bank_of

   function automatic logic [BANK_AW-1:0] index_of(input logic [BANK_AW:0] a);
      return a[BANK_AW:1];
   endfunction : index_of

   // -------------------------------------------------------------------
   // Slow-parts pin synchroniser
   // -------------------------------------------------------------------
   // Two flops; only the second is read by the controller
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_meta <= 1'b0;
         slow      <= 1'b0;
      end else begin
         slow_meta <= slow_parts;
         slow      <= slow_meta;
      end
   end

   // -------------------------------------------------------------------
   // Request decode
   // -------------------------------------------------------------------
   // Data block has no instruction port at all
   assign i_take      = HAS_IPORT && ireq;
   assign d_take      = dreq;
   assign start       = (state == scd_pkg::ST_IDLE) && !refresh_req
                        && (i_take || d_take);
   assign start_data  = !i_take;                                   // Instruction first
   // The instruction port never writes
   assign start_write = start_data && dwrite;
   assign start_addr  = start_data ? daddr : iaddr;

   // First word slot: writes one cycle ahead of reads, slow parts one later
   always_comb begin
      first_slot = 1'b0;
      if (!got_first) begin
         if (acc_write) begin
            first_slot = slow ? (state == scd_pkg::ST_COL)
                              : (state == scd_pkg::ST_ROW);
         end else begin
            first_slot = slow ? (state == scd_pkg::ST_WAIT)
                              : (state == scd_pkg::ST_COL);
         end
      end
   end

   assign burst_req = acc_data ? dbreq : ibreq;
   // A new address or a refresh ends the open row; no row compare is made.
   // The request still held in the first word's ready cycle is the one
   // being served, so requests count only from the cycle after it
   assign preempt   = past_first && (state == scd_pkg::ST_ACCESS)
                      && (i_take || d_take || refresh_req);
   // Later words come one per cycle while the burst request stands
   assign deliver   = first_slot
                      || (got_first && !preempt && burst_req
                          && ((state == scd_pkg::ST_COL)
                              || (state == scd_pkg::ST_ACCESS)));
   assign bank      = word_addr[0];

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         scd_pkg::ST_IDLE: begin
            if (refresh_req) begin
               next_state = scd_pkg::ST_REF1;
            end else if (start) begin
               next_state = scd_pkg::ST_ROW;
            end
         end
         scd_pkg::ST_ROW: begin
            next_state = scd_pkg::ST_COL;
         end
         scd_pkg::ST_COL: begin
            next_state = (slow && !acc_write) ? scd_pkg::ST_WAIT
                                              : scd_pkg::ST_ACCESS;
         end
         scd_pkg::ST_WAIT: begin
            next_state = scd_pkg::ST_ACCESS;
         end
         scd_pkg::ST_ACCESS: begin
            // Suspended bursts stay here with the row open
            if (preempt) begin
               next_state = scd_pkg::ST_PRE;
            end
         end
         scd_pkg::ST_PRE: begin
            next_state = scd_pkg::ST_IDLE;
         end
         scd_pkg::ST_REF1: begin
            next_state = scd_pkg::ST_REF2;
         end
         scd_pkg::ST_REF2: begin
            next_state = scd_pkg::ST_PRE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= scd_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // -------------------------------------------------------------------
   // Access descriptor
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_data  <= 1'b0;
         acc_write <= 1'b0;
         got_first <= 1'b0;
         past_first <= 1'b0;
      end else begin
         past_first <= got_first;
         if (start) begin
            acc_data  <= start_data;
            acc_write <= start_write;
            got_first <= 1'b0;
         end else if (first_slot) begin
            got_first <= 1'b1;
         end else if (state == scd_pkg::ST_PRE) begin
            got_first <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Address counters
   // -------------------------------------------------------------------
   // Word counter: LSB is the active-bank flag and flips every word
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_addr <= '0;
      end else if (start) begin
         word_addr <= start_addr;
      end else if (deliver) begin
         word_addr <= word_addr + 1'b1;
      end
   end

   assign active_bank_flag = word_addr[0];

   // Separate counter per bank, each stepping only on its own words, so
   // one bank fetches the next word while the other drives the bus
   for (genvar b = 0; b < scd_pkg::NUM_BANKS; b++) begin : g_cnt
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            bank_addr[b] <= '0;
         end else if (start) begin
            // Even bank starts one word up when the burst begins odd
            bank_addr[b] <= index_of(start_addr)
                            + BANK_AW'((b == 0) && bank_of(start_addr));
         end else if (deliver && (bank == 1'(b))) begin
            bank_addr[b] <= bank_addr[b] + 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Write latches, one set per bank
   // -------------------------------------------------------------------
   // A set opens only in the cycles its bank is active, so it holds its
   // word across the following cycle while the other set takes the next
   for (genvar b = 0; b < scd_pkg::NUM_BANKS; b++) begin : g_lat
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            latch_data[b] <= '0;
            latch_addr[b] <= '0;
         end else if (deliver && acc_write && (bank == 1'(b))) begin
            latch_data[b] <= dbus_wdata;
            latch_addr[b] <= bank_addr[b];
         end
      end

      // New capture wins over the commit of the previous word
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            latch_full[b] <= 1'b0;
         end else if (deliver && acc_write && (bank == 1'(b))) begin
            latch_full[b] <= 1'b1;
         end else if (bank_wr[b]) begin
            latch_full[b] <= 1'b0;
         end
      end

      // Column strobe low qualifies the commit
      assign bank_wr[b] = latch_full[b] && !cas_n;

      scd_bank_mem #(
         .WIDTH (WIDTH),
         .AW    (BANK_AW)
      ) u_bank (
         .ref_clk (ref_clk),
         .rst_n   (rst_n),
         .addr    (bank_addr[b]),
         .wr_addr (latch_addr[b]),
         .wr_en   (bank_wr[b]),
         .wdata   (latch_data[b]),
         .rdata   (bank_rdata[b])
      );
   end

   // -------------------------------------------------------------------
   // Row and column strobes
   // -------------------------------------------------------------------
   // Column strobe stays low for the whole burst; only the column moves
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ras_n <= scd_pkg::STROBE_IDLE_N;
         cas_n <= scd_pkg::STROBE_IDLE_N;
      end else begin
         unique case (next_state)
            scd_pkg::ST_ROW: begin
               ras_n <= 1'b0;
               cas_n <= scd_pkg::STROBE_IDLE_N;
            end
            scd_pkg::ST_COL, scd_pkg::ST_WAIT, scd_pkg::ST_ACCESS: begin
               ras_n <= 1'b0;
               cas_n <= 1'b0;
            end
            scd_pkg::ST_REF1: begin
               // Column before row starts an internal refresh
               ras_n <= scd_pkg::STROBE_IDLE_N;
               cas_n <= 1'b0;
            end
            scd_pkg::ST_REF2: begin
               ras_n <= 1'b0;
               cas_n <= 1'b0;
            end
            scd_pkg::ST_IDLE, scd_pkg::ST_PRE: begin
               ras_n <= scd_pkg::STROBE_IDLE_N;
               cas_n <= scd_pkg::STROBE_IDLE_N;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_ack <= 1'b0;
      end else begin
         refresh_ack <= (state == scd_pkg::ST_IDLE) && refresh_req;
      end
   end

   // -------------------------------------------------------------------
   // Instruction bus
   // -------------------------------------------------------------------
   // One enable per bank keeps the banks apart on the bus
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irdy         <= 1'b0;
         idata        <= '0;
         ibus_oe_even <= 1'b0;
         ibus_oe_odd  <= 1'b0;
      end else begin
         irdy         <= deliver && !acc_data;
         ibus_oe_even <= deliver && !acc_data && (bank == scd_pkg::BANK_EVEN);
         ibus_oe_odd  <= deliver && !acc_data && (bank == scd_pkg::BANK_ODD);
         if (deliver && !acc_data) begin
            idata <= bank_rdata[bank];
         end
      end
   end

   // -------------------------------------------------------------------
   // Data bus
   // -------------------------------------------------------------------
   // Drivers on only for data reads, never during instruction fetch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         drdy       <= 1'b0;
         dbus_rdata <= '0;
         dbus_oe    <= 1'b0;
      end else begin
         drdy    <= deliver && acc_data;
         dbus_oe <= deliver && acc_data && !acc_write;
         if (deliver && acc_data && !acc_write) begin
            dbus_rdata <= bank_rdata[bank];
         end
      end
   end

endmodule : interleaved_static_column_dram_port

// [sim/interleaved_static_column_dram_port_tb.sv]
// Self-checking bench for the interleaved static-column memory port
`timescale 1ns/1ps

module interleaved_static_column_dram_port_tb;
   logic ref_clk = 1'b0, rst_n, slow_parts, refresh_req;
   logic ireq, ibreq, irdy, ibus_oe_even, ibus_oe_odd, dreq, dwrite, dbreq;
   logic drdy, dbus_oe, refresh_ack, ras_n, cas_n, active_bank_flag;
   logic [20:0] iaddr, daddr, a;
   logic [31:0] idata, dbus_wdata, dbus_rdata, mem[int];
   int seed, fails, num_checks, rc, i;

   always #2.5 ref_clk = ~ref_clk;

   interleaved_static_column_dram_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .slow_parts(slow_parts), .ireq(ireq), .iaddr(iaddr), .ibreq(ibreq), .irdy(irdy),
      .idata(idata), .ibus_oe_even(ibus_oe_even), .ibus_oe_odd(ibus_oe_odd),
      .dreq(dreq), .daddr(daddr), .dwrite(dwrite), .dbreq(dbreq),
      .dbus_wdata(dbus_wdata), .drdy(drdy), .dbus_rdata(dbus_rdata), .dbus_oe(dbus_oe),
      .refresh_req(refresh_req), .refresh_ack(refresh_ack), .ras_n(ras_n),
      .cas_n(cas_n), .active_bank_flag(active_bank_flag));

   scd_cpu_model i_cpu (.ref_clk(ref_clk), .irdy(irdy), .idata(idata), .drdy(drdy),
      .dbus_rdata(dbus_rdata), .ras_n(ras_n), .ireq(ireq), .iaddr(iaddr), .ibreq(ibreq),
      .dreq(dreq), .daddr(daddr), .dwrite(dwrite), .dbreq(dbreq),
      .dbus_wdata(dbus_wdata));

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic test_done();
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Refresh request held until acknowledged, then room to settle in idle
   task automatic do_refresh(output int cnt);
      cnt = 0;
      @(posedge ref_clk);
      refresh_req <= 1'b1;
      do begin
         @(negedge ref_clk);
         cnt++;
      end while (refresh_ack !== 1'b1 && cnt < 50);
      @(posedge ref_clk);
      refresh_req <= 1'b0;
      if (cnt >= 50) begin
         fails++;
         test_done();
      end
      repeat (2) @(posedge ref_clk);
   endtask : do_refresh

   // Burst start kept low in its 16-word span so no counter wraps
   function automatic logic [20:0] base();
      logic [31:0] r;
      r = $random(seed);
      return {r[20:4], 1'b0, r[2:0]};
   endfunction : base

   // One transfer with expected data from the bench's own memory image
   task automatic run(input bit ib, input bit wr, input logic [20:0] ad, input int n);
      int k;
      if (wr) begin
         i_cpu.wq.delete();
         for (k = 0; k < n; k++) begin
            i_cpu.wq.push_back($random(seed));
            mem[ad + k] = i_cpu.wq[k];
         end
      end
      i_cpu.xfer(ib, wr, ad, n);
      if (i_cpu.tmo) begin
         fails++;
         test_done();
      end
      check(i_cpu.t_end - i_cpu.lat, n - 1);
      if (!wr) for (k = 0; k < n; k++) check(i_cpu.rq[k], mem[ad + k]);
   endtask : run

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      seed = 39; fails = 0; num_checks = 0;
      rst_n = 1'b0; slow_parts = 1'b0; refresh_req = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Refresh and fetch raised on the same edge
      fork
         do_refresh(rc);
         i_cpu.xfer(1'b1, 1'b0, 21'h0, 1);
      join
      check(32'(rc < i_cpu.lat && !i_cpu.tmo), 32'h1);
      a = base() | 21'h1;
      do_refresh(rc);
      run(1'b0, 1'b1, a, 8);
      check(i_cpu.lat, 32'h3);
      do_refresh(rc);
      run(1'b1, 1'b0, a, 8);
      check(i_cpu.lat, 32'h4);
      run(1'b0, 1'b0, a + 21'h1, 6);
      // Slow parts stretch the first word
      slow_parts <= 1'b1;
      do_refresh(rc);
      run(1'b1, 1'b0, a, 4);
      check(i_cpu.lat, 32'h5);
      do_refresh(rc);
      run(1'b0, 1'b0, a + 21'h2, 3);
      check(i_cpu.lat, 32'h5);
      slow_parts <= 1'b0;
      repeat (4) @(posedge ref_clk);
      // Random write-then-read bursts over both ports
      for (i = 0; i < 10; i++) begin
         a = base();
         rc = 1 + ({$random(seed)} % 8);
         run(1'b0, 1'b1, a, rc);
         run(rc[0], 1'b0, a, rc);
      end
      test_done();
   end
endmodule : interleaved_static_column_dram_port_tb

// [sim/scd_cpu_model.sv]
// Processor-side bus model: issues fetches, data reads and data writes
`timescale 1ns/1ps

module scd_cpu_model (
   input  wire logic        ref_clk,
   input  wire logic        irdy,
   input  wire logic [31:0] idata,
   input  wire logic        drdy,
   input  wire logic [31:0] dbus_rdata,
   input  wire logic        ras_n,
   output logic             ireq,
   output logic [20:0]      iaddr,
   output logic             ibreq,
   output logic             dreq,
   output logic [20:0]      daddr,
   output logic             dwrite,
   output logic             dbreq,
   output logic [31:0]      dbus_wdata
);
   logic [31:0] wq[$];
   logic [31:0] rq[$];
   int          lat;
   int          t_end;
   bit          tmo;

   // Idle bus values at time zero
   initial begin
      ireq = 1'b0; iaddr = 21'h0; ibreq = 1'b0; dreq = 1'b0; daddr = 21'h0;
      dwrite = 1'b0; dbreq = 1'b0; dbus_wdata = 32'h5a5a_5a5a;
   end

   // -------------------------------------------------------------------
   // One transfer; outputs sampled mid-cycle, changes made at the edge
   // -------------------------------------------------------------------
   // Write data advances at the capture edge, which only fast parts make
   // predictable, so writes are issued with fast parts only
   task automatic xfer(input bit ib, input bit wr, input logic [20:0] a, input int n);
      int got;
      int w;
      bit hi, cap, nxt, rdy;
      logic [31:0] d;
      got = 0; w = 0; hi = 0; cap = 0; lat = 0; tmo = 0; t_end = 0;
      rq.delete();
      @(posedge ref_clk);
      if (ib) begin
         ireq <= 1'b1; iaddr <= a; ibreq <= (n > 1);
      end else begin
         dreq <= 1'b1; daddr <= a; dwrite <= wr; dbreq <= (n > 1);
         if (wr) dbus_wdata <= wq[0];
      end
      while (got < n && !tmo) begin
         @(negedge ref_clk);
         t_end++;
         tmo = (t_end > 200);
         hi = hi | ras_n;
         rdy = ib ? irdy : drdy;
         d = ib ? idata : dbus_rdata;
         nxt = wr && ((hi && !ras_n && !cap) || drdy);
         @(posedge ref_clk);
         if (nxt) begin
            cap = 1; w++;
            dbus_wdata <= (w < n) ? wq[w] : ~dbus_wdata; // Released bus flips
         end
         if (rdy) begin
            if (got == 0) begin
               lat = t_end; ireq <= 1'b0; dreq <= 1'b0;
            end
            if (!wr) rq.push_back(d);
            got++;
            if (got == n - 1) begin
               ibreq <= 1'b0; dbreq <= 1'b0;
            end
         end
      end
   endtask : xfer
endmodule : scd_cpu_model

// [sim/scd_port_asserts.sv]
// Pin-level timing checks for the interleaved static-column memory port
`timescale 1ns/1ps

module scd_port_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow_parts,
   input wire logic ireq,
   input wire logic ibreq,
   input wire logic irdy,
   input wire logic ibus_oe_even,
   input wire logic ibus_oe_odd,
   input wire logic dreq,
   input wire logic dwrite,
   input wire logic drdy,
   input wire logic dbus_oe,
   input wire logic refresh_req,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic active_bank_flag
);
   // -------------------------------------------------------------------
   // One clock domain, so clock and reset are given once
   // -------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Row strobe falling with column idle marks a taken access
   a_read_fast_lat: assert property (
      $fell(ras_n) && cas_n && ireq && !slow_parts && !$past(slow_parts, 4)
      |-> !irdy[*2] ##1 irdy) else $error("fast fetch first word late or early");
   a_read_slow_lat: assert property (
      $fell(ras_n) && cas_n && ireq && slow_parts && $past(slow_parts, 4)
      |-> !irdy[*3] ##1 irdy) else $error("slow fetch first word late or early");
   a_write_fast_lat: assert property (
      $fell(ras_n) && cas_n && dreq && dwrite && !ireq && !slow_parts
      && !$past(slow_parts, 4) |-> !drdy ##1 drdy) else $error("write not one cycle short");
   a_burst_rate: assert property (
      irdy && $past(irdy) && ibreq && !ireq && !dreq && !refresh_req |=> irdy)
      else $error("burst word not delivered next cycle");
   a_bank_alt: assert property (
      irdy && $past(irdy) |-> ibus_oe_odd != $past(ibus_oe_odd))
      else $error("consecutive words from the same bank");
   a_ibus_iso: assert property (
      (ibus_oe_even || ibus_oe_odd) == irdy && !(ibus_oe_even && ibus_oe_odd))
      else $error("instruction bank drivers not exclusive");
   a_dbus_quiet: assert property (
      dbus_oe |-> drdy && !dwrite && !irdy) else $error("data bus driven out of a read");
   // Opening a row reloads the word counter, so that cycle is left out
   a_flag_toggle: assert property (
      !$fell(ras_n) |-> (irdy || drdy) == $changed(active_bank_flag))
      else $error("bank flag not per word");
   a_static_col: assert property (
      irdy |-> !ras_n && !cas_n && !$past(cas_n)) else $error("column strobe recycled");
   a_write_commit: assert property (
      drdy && dwrite |-> !cas_n && !ras_n) else $error("write word without column strobe");
   a_precharge: assert property (
      $fell(ras_n) |-> $past(ras_n, 2)) else $error("row opened without precharge");
   a_refresh_first: assert property (
      $fell(ras_n) && cas_n |-> !$past(refresh_req)) else $error("access beat refresh");
endmodule : scd_port_asserts

bind interleaved_static_column_dram_port scd_port_asserts i_chk (.*);
